//--- core/code_change_detect.sv
// Tracks one loopback code detector and flags every change of its level.
// Assumes code_seen and detect_en come from logic on the same clock.
`timescale 1ns/1ps

module code_change_detect
    import lbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic detect_en,
    input wire logic code_seen,
    code_change_if.producer link
);

    typedef struct packed {
        logic present;
        logic change;
    } detect_state_type;

    detect_state_type state_q;
    detect_state_type state_d;

    // The level counts only while detection is enabled; a change is any
    // difference from the previous level, rising or falling.
    always_comb begin
        state_d = state_q;
        state_d.present = code_seen & detect_en;
        state_d.change = state_d.present ^ state_q.present;
    end

    // State register.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign link.present = state_q.present;
    assign link.change = state_q.change;

endmodule // code_change_detect

//--- core/code_change_if.sv
// Interface carrying one code detector's present level and change pulse.
// Assumes producer and consumer share the same clock.
`timescale 1ns/1ps

interface code_change_if;

    logic present;
    logic change;

    // The edge detector drives both signals.
    modport producer (
        output present,
        output change
    );

    // The register logic only reads them.
    modport consumer (
        input present,
        input change
    );

endinterface

//--- core/lbc_pkg.sv
// Constants for the loopback code change interrupt block.
// Assumes an 8-bit register port and one 100 MHz clock domain.
package lbc_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h1D;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h1E;
    localparam logic [ADDR_W-1:0] OFS_OVERRUN = 8'h1F;
    localparam logic [ADDR_W-1:0] OFS_ACT_COUNT = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_DEACT_COUNT = 8'h21;

    // Field positions, shared by the enable, status and overrun registers.
    localparam int BIT_ACT_PRESENT = 3;
    localparam int BIT_DEACT_PRESENT = 2;
    localparam int BIT_ACT_CHANGE = 1;
    localparam int BIT_DEACT_CHANGE = 0;

    // Reset values.
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic RESET_BIT = 1'b0;

    // Change counters saturate here.
    localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
    localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;

endpackage

//--- core/loopback_code_change_irq.sv
// Interrupt and status logic for loopback activation and deactivation codes.
// Assumes the code detectors and the register port run on this clock.
//
// What this block does
// - Activation change interrupt enable is read/write; one allows, zero suppresses.
// - Deactivation change interrupt enable is read/write; one allows, zero suppresses.
// - Activation change event fires when detection starts and when it stops.
// - Deactivation change event fires when detection starts and when it stops.
// - Status bit 3 is read-only, high while activation code is detected.
// - Status bit 2 is read-only, high while deactivation code is detected.
// - Status bit 1 latches activation changes; reading the register clears it.
// - Status bit 0 latches deactivation changes; reading the register clears it.
// - Status bits 7 to 4 are reserved in this mode.
`timescale 1ns/1ps

module loopback_code_change_irq
    import lbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic activation_detect_en,
    input wire logic deactivation_detect_en,
    input wire logic activation_code_seen,
    input wire logic deactivation_code_seen,
    output logic [DATA_W-1:0] read_data,
    output logic irq,
    output logic activation_code_present,
    output logic deactivation_code_present
);

    // All state of the register side.
    typedef struct packed {
        logic act_irq_en;
        logic deact_irq_en;
        logic act_flag;
        logic deact_flag;
        logic act_overrun;
        logic deact_overrun;
        logic [DATA_W-1:0] act_count;
        logic [DATA_W-1:0] deact_count;
        logic [DATA_W-1:0] read_data;
        logic irq;
    } irq_state_type;

    irq_state_type state_q;
    irq_state_type state_d;

    code_change_if act_link ();
    code_change_if deact_link ();

    // Decoded accesses for the current cycle.
    logic wr_enable;
    logic wr_status;
    logic wr_overrun;
    logic rd_status;
    logic rd_act_count;
    logic rd_deact_count;

    // A sticky flag: a new event wins over any clear in the same cycle.
    function automatic logic sticky_next(
        input logic flag,
        input logic set,
        input logic clear
    );
        logic result;
        result = flag;
        if (set) begin
            result = 1'b1;
        end else if (clear) begin
            result = 1'b0;
        end
        return result;
    endfunction

    // A change counter: cleared by its read, but an event in that cycle
    // restarts it at one, and it holds at its maximum rather than wrapping.
    function automatic logic [DATA_W-1:0] count_next(
        input logic [DATA_W-1:0] count,
        input logic event_seen,
        input logic clear
    );
        logic [DATA_W-1:0] result;
        result = count;
        if (clear) begin
            result = event_seen ? COUNT_ONE : RESET_BYTE;
        end else if (event_seen && count != COUNT_MAX) begin
            result = count + COUNT_ONE;
        end
        return result;
    endfunction

    // Level and change tracking for the activation code.
    code_change_detect act_detect (
        .clock(clock),
        .rst_b(rst_b),
        .detect_en(activation_detect_en),
        .code_seen(activation_code_seen),
        .link(act_link.producer)
    );

    // Level and change tracking for the deactivation code.
    code_change_detect deact_detect (
        .clock(clock),
        .rst_b(rst_b),
        .detect_en(deactivation_detect_en),
        .code_seen(deactivation_code_seen),
        .link(deact_link.producer)
    );

    // Address decode of the plain register port.
    always_comb begin
        wr_enable = 1'b0;
        wr_status = 1'b0;
        wr_overrun = 1'b0;
        rd_status = 1'b0;
        rd_act_count = 1'b0;
        rd_deact_count = 1'b0;
        if (address == OFS_IRQ_ENABLE) begin
            wr_enable = write_strobe;
        end else if (address == OFS_IRQ_STATUS) begin
            wr_status = write_strobe;
            rd_status = read_strobe;
        end else if (address == OFS_OVERRUN) begin
            wr_overrun = write_strobe;
        end else if (address == OFS_ACT_COUNT) begin
            rd_act_count = read_strobe;
        end else if (address == OFS_DEACT_COUNT) begin
            rd_deact_count = read_strobe;
        end
    end

    // Next state of enables, flags, counters, read data and interrupt.
    always_comb begin
        state_d = state_q;

        // Enables are plain read/write bits steering the interrupt.
        if (wr_enable) begin
            state_d.act_irq_en = write_data[BIT_ACT_CHANGE];
            state_d.deact_irq_en = write_data[BIT_DEACT_CHANGE];
        end

        // Change flags clear on a status read or a written one.
        state_d.act_flag = sticky_next(state_q.act_flag, act_link.change,
            rd_status | (wr_status & write_data[BIT_ACT_CHANGE]));
        state_d.deact_flag = sticky_next(state_q.deact_flag, deact_link.change,
            rd_status | (wr_status & write_data[BIT_DEACT_CHANGE]));

        // A change while its flag is still pending is recorded as an overrun.
        state_d.act_overrun = sticky_next(state_q.act_overrun,
            act_link.change & state_q.act_flag,
            wr_overrun & write_data[BIT_ACT_CHANGE]);
        state_d.deact_overrun = sticky_next(state_q.deact_overrun,
            deact_link.change & state_q.deact_flag,
            wr_overrun & write_data[BIT_DEACT_CHANGE]);

        // Change counters for software that wants more than one flag.
        state_d.act_count = count_next(state_q.act_count, act_link.change,
            rd_act_count);
        state_d.deact_count = count_next(state_q.deact_count, deact_link.change,
            rd_deact_count);

        // Read data stand only in the cycle after the read strobe.
        state_d.read_data = RESET_BYTE;
        if (read_strobe) begin
            if (address == OFS_IRQ_ENABLE) begin
                state_d.read_data[BIT_ACT_CHANGE] = state_q.act_irq_en;
                state_d.read_data[BIT_DEACT_CHANGE] = state_q.deact_irq_en;
            end else if (address == OFS_IRQ_STATUS) begin
                // Upper nibble stays zero as reserved.
                state_d.read_data[BIT_ACT_PRESENT] = act_link.present;
                state_d.read_data[BIT_DEACT_PRESENT] = deact_link.present;
                state_d.read_data[BIT_ACT_CHANGE] = state_q.act_flag;
                state_d.read_data[BIT_DEACT_CHANGE] = state_q.deact_flag;
            end else if (address == OFS_OVERRUN) begin
                state_d.read_data[BIT_ACT_CHANGE] = state_q.act_overrun;
                state_d.read_data[BIT_DEACT_CHANGE] = state_q.deact_overrun;
            end else if (address == OFS_ACT_COUNT) begin
                state_d.read_data = state_q.act_count;
            end else if (address == OFS_DEACT_COUNT) begin
                state_d.read_data = state_q.deact_count;
            end
        end

        // The interrupt follows the next flags so it rises with them.
        state_d.irq = (state_d.act_flag & state_d.act_irq_en)
            | (state_d.deact_flag & state_d.deact_irq_en);
    end

    // State register; everything clears to zero.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign read_data = state_q.read_data;
    assign irq = state_q.irq;
    assign activation_code_present = act_link.present;
    assign deactivation_code_present = deact_link.present;

endmodule // loopback_code_change_irq

//--- tb/far_end_code_source.sv
// Far-end line equipment that sends loopback activation and deactivation codes.
// Assumes the bench calls send_codes from its main sequence.
`timescale 1ns/1ps
module far_end_code_source (
    input wire logic clock,
    output logic activation_code_seen,
    output logic deactivation_code_seen
);
    // An idle line carries neither code.
    initial begin
        activation_code_seen = 1'b0;
        deactivation_code_seen = 1'b0;
    end
    // Starts or stops each code just after a clock edge.
    task automatic send_codes(input logic act, input logic deact);
        @(posedge clock);
        activation_code_seen <= act;
        deactivation_code_seen <= deact;
    endtask
endmodule // far_end_code_source

//--- tb/lbc_irq_monitor.sv
// Concurrent checks on the loopback code change interrupt block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lbc_irq_monitor
    import lbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic activation_detect_en,
    input wire logic deactivation_detect_en,
    input wire logic activation_code_seen,
    input wire logic deactivation_code_seen,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic irq,
    input wire logic activation_code_present,
    input wire logic deactivation_code_present
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [1:0] en_q;
    logic [1:0] last_q;
    logic [1:0] chg;
    // Mirrors the enable bits and remembers the previous code levels.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= 2'b00;
            last_q <= 2'b00;
        end else begin
            last_q <= {activation_code_present, deactivation_code_present};
            if (write_strobe && address == OFS_IRQ_ENABLE) begin
                en_q <= write_data[1:0];
            end
        end
    end
    // A set bit marks a level that moved since the previous edge.
    assign chg = {activation_code_present, deactivation_code_present} ^ last_q;
    a_act_present: assert property (activation_code_present ==
        $past(activation_code_seen & activation_detect_en)) else $error("act level");
    a_deact_present: assert property (deactivation_code_present ==
        $past(deactivation_code_seen & deactivation_detect_en)) else $error("deact level");
    a_read_idle: assert property (!$past(read_strobe) |-> read_data == 8'h00)
        else $error("idle data");
    a_status_upper: assert property ($past(read_strobe && address == OFS_IRQ_STATUS) |->
        read_data[7:2] == {4'h0, last_q}) else $error("status bits");
    a_act_irq: assert property (chg[1] && en_q[1] && !write_strobe |=> irq)
        else $error("act irq");
    a_deact_irq: assert property (chg[0] && en_q[0] && !write_strobe |=> irq)
        else $error("deact irq");
    a_irq_masked: assert property (irq |-> (en_q | $past(en_q)) != 2'b00)
        else $error("irq mask");
    a_read_clears: assert property (read_strobe && address == OFS_IRQ_STATUS && chg == 2'b00
        ##1 chg == 2'b00 |=> !irq) else $error("read clear");
    c_irq_rise: cover property ($rose(irq));
    c_flag_read: cover property (read_strobe && address == OFS_IRQ_STATUS ##1 read_data[1]);
    c_deact_fall: cover property ($fell(deactivation_code_present));
endmodule // lbc_irq_monitor
bind loopback_code_change_irq lbc_irq_monitor lbc_irq_monitor_inst (.clock(clock), .rst_b(rst_b),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .activation_detect_en(activation_detect_en),
    .deactivation_detect_en(deactivation_detect_en), .activation_code_seen(activation_code_seen),
    .deactivation_code_seen(deactivation_code_seen), .read_data(read_data), .irq(irq),
    .activation_code_present(activation_code_present),
    .deactivation_code_present(deactivation_code_present));

//--- tb/test_loopback_code_change_irq.sv
// Self-checking bench for the loopback code change interrupt block.
// Assumes the far-end model drives the detector inputs and the checker is bound.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_loopback_code_change_irq
    import lbc_pkg::*;
;
    logic clock, rst_b, write_strobe, read_strobe, act_en, deact_en, act_seen, deact_seen;
    logic irq, act_present, deact_present;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] write_data, read_data;
    int num_errors = 0;
    int n_compared = 0;
    loopback_code_change_irq loopback_code_change_irq_inst (.clock(clock), .rst_b(rst_b),
        .address(address), .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .activation_detect_en(act_en),
        .deactivation_detect_en(deact_en), .activation_code_seen(act_seen),
        .deactivation_code_seen(deact_seen), .read_data(read_data), .irq(irq),
        .activation_code_present(act_present), .deactivation_code_present(deact_present));
    far_end_code_source far_end_code_source_inst (.clock(clock),
        .activation_code_seen(act_seen), .deactivation_code_seen(deact_seen));
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    // One-cycle register read, judged in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        `CHK(read_data, e)
    endtask
    // Waits a bounded time for the interrupt level; a miss ends the run.
    task automatic wait_irq(input logic e);
        for (int i = 0; i < 8 && irq !== e; i++) begin
            @(posedge clock);
            #1;
        end
        `CHK(irq, e)
        if (irq !== e) begin
            final_report();
        end
    endtask
    // Reset values, enable read/write and an unmapped read.
    task automatic t_regs();
        `CHK(irq, 1'b0)
        rd(OFS_IRQ_ENABLE, 8'h00);
        rd(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'hFF);
        rd(OFS_IRQ_ENABLE, 8'h03);
        rd(8'h00, 8'h00);
        $display("t_regs done");
    endtask
    // Activation code starts and stops; each edge flags and interrupts.
    task automatic t_act_edges();
        wr(OFS_IRQ_ENABLE, 8'h02);
        far_end_code_source_inst.send_codes(1'b1, 1'b0);
        wait_irq(1'b1);
        rd(OFS_IRQ_STATUS, 8'h0A);
        wait_irq(1'b0);
        rd(OFS_IRQ_STATUS, 8'h08);
        far_end_code_source_inst.send_codes(1'b0, 1'b0);
        wait_irq(1'b1);
        rd(OFS_IRQ_STATUS, 8'h02);
        wait_irq(1'b0);
        $display("t_act_edges done");
    endtask
    // Deactivation change while masked, then unmasked, then detection disabled.
    task automatic t_deact_masked();
        far_end_code_source_inst.send_codes(1'b0, 1'b1);
        repeat (4) @(posedge clock);
        #1;
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_ENABLE, 8'h01);
        wait_irq(1'b1);
        rd(OFS_IRQ_STATUS, 8'h05);
        wait_irq(1'b0);
        @(posedge clock);
        deact_en <= 1'b0;
        wait_irq(1'b1);
        rd(OFS_IRQ_STATUS, 8'h01);
        far_end_code_source_inst.send_codes(1'b0, 1'b0);
        deact_en <= 1'b1;
        repeat (3) @(posedge clock);
        rd(OFS_IRQ_STATUS, 8'h00);
        `CHK(irq, 1'b0)
        $display("t_deact_masked done");
    endtask
    // Change counters, overrun on a second change and write-one clears.
    task automatic t_count_overrun();
        rd(OFS_ACT_COUNT, 8'h02);
        rd(OFS_DEACT_COUNT, 8'h02);
        rd(OFS_ACT_COUNT, 8'h00);
        far_end_code_source_inst.send_codes(1'b1, 1'b0);
        far_end_code_source_inst.send_codes(1'b0, 1'b0);
        repeat (3) @(posedge clock);
        #1;
        `CHK(irq, 1'b0)
        rd(OFS_OVERRUN, 8'h02);
        wr(OFS_OVERRUN, 8'h02);
        rd(OFS_OVERRUN, 8'h00);
        wr(OFS_IRQ_STATUS, 8'h02);
        rd(OFS_IRQ_STATUS, 8'h00);
        rd(OFS_ACT_COUNT, 8'h02);
        $display("t_count_overrun done");
    endtask
    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Reset, then every scenario in turn.
    initial begin
        rst_b = 1'b0;
        address = 8'h00;
        write_data = 8'h00;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        act_en = 1'b1;
        deact_en = 1'b1;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_act_edges();
        t_deact_masked();
        t_count_overrun();
        final_report();
    end
endmodule // test_loopback_code_change_irq
